// ---- logic/tlm_pkg.sv ----
// package: constants and carriers for the two-level memory mapper
package tlm_pkg;

   // ==========================================================
   // table geometry
   localparam int SEG_ENTRIES   = 128;
   localparam int SEG_AW        = 7;
   localparam int BLK_TABLES    = 8;
   localparam int BLK_PER_TABLE = 32;
   localparam int BLK_AW        = 8;
   localparam int OFF_BLK_LSB   = 11;
   localparam int SRAM_BW_DEF   = 8;
   localparam int CLR_LAST      = 255;

   // ==========================================================
   // register byte offsets (12-bit word aligned)
   localparam logic [11:0] OFS_CTRL     = 12'h000;
   localparam logic [11:0] OFS_DIST     = 12'h004;
   localparam logic [11:0] OFS_STATUS   = 12'h008;
   localparam logic [11:0] OFS_IRQ_STAT = 12'h00c;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h010;
   localparam logic [11:0] OFS_LAST_VIO = 12'h014;
   localparam logic [11:0] OFS_SEG_BASE = 12'h400;
   localparam logic [11:0] OFS_BLK_BASE = 12'h800;
   localparam logic [1:0]  WIN_SEG      = 2'h1;
   localparam logic [1:0]  WIN_BLK      = 2'h2;

   // ==========================================================
   // field positions and reset values
   localparam int CTRL_CLEAR_BIT = 0;
   localparam int DIST_SYS_BIT   = 0;
   localparam int DIST_CD_BIT    = 1;
   localparam int DIST_STACK_BIT = 2;
   localparam int IRQ_PROT_BIT   = 0;
   localparam int IRQ_NONEX_BIT  = 1;
   localparam logic [2:0] DIST_RST     = 3'h0;
   localparam logic [1:0] IRQ_MASK_RST = 2'h0;

   // ==========================================================
   // access spaces and routes
   localparam logic [1:0] SPACE_CODE  = 2'h0;
   localparam logic [1:0] SPACE_DATA  = 2'h1;
   localparam logic [1:0] SPACE_STACK = 2'h2;

   typedef enum logic [1:0] {
      TLM_ROUTE_TARGET = 2'h0,
      TLM_ROUTE_SRAM   = 2'h1,
      TLM_ROUTE_NONE   = 2'h2
   } tlm_route_t;

   typedef enum logic [1:0] {
      TLM_MAP_USER   = 2'h0,
      TLM_MAP_MAPPED = 2'h1,
      TLM_MAP_NONEX  = 2'h2
   } tlm_map_t;

   typedef enum logic [2:0] {
      TLM_SP_NONE       = 3'h0,
      TLM_SP_SYS_ONLY   = 3'h1,
      TLM_SP_NORM_ONLY  = 3'h2,
      TLM_SP_CODE_ONLY  = 3'h3,
      TLM_SP_DATA_ONLY  = 3'h4,
      TLM_SP_WP_ALL     = 3'h5,
      TLM_SP_WP_DATA    = 3'h6
   } tlm_seg_prot_t;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic [6:0]  seg;
      logic [15:0] off;
      logic        wr;
      logic        sys;
      logic [1:0]  space;
   } tlm_acc_t;

   typedef struct packed {
      logic [2:0]    group;
      tlm_seg_prot_t prot;
      tlm_map_t      map;
   } tlm_seg_ent_t;

   typedef struct packed {
      logic       write_protect;
      logic       data_only;
      logic [7:0] blk;
      logic       sub;
   } tlm_blk_ent_t;

   typedef struct packed {
      tlm_route_t route;
      logic [7:0] blk;
      logic       wr_ok;
      logic       viol;
   } tlm_res_t;

   localparam int SEG_WIDTH = $bits(tlm_seg_ent_t);
   localparam int BLK_WIDTH = $bits(tlm_blk_ent_t);

endpackage

// ---- logic/tlm_ram.sv ----
// memory: one write port, one registered read port
`timescale 1ns/1ps
module tlm_ram #(
   parameter int DATA_W = 8,
   parameter int AW     = 7
) (
   // clock
   input  wire logic              clk,
   // write port
   input  wire logic              we,
   input  wire logic [AW-1:0]     waddr,
   input  wire logic [DATA_W-1:0] wdata,
   // read port
   input  wire logic [AW-1:0]     raddr,
   output logic      [DATA_W-1:0] rdata
);

   logic [DATA_W-1:0] mem [2**AW];

   // ==========================================================
   // write
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // ==========================================================
   // read
   always_ff @(posedge clk) begin
      rdata <= mem[raddr];
   end

endmodule // tlm_ram

// ---- logic/tlm_mapper.sv ----
// top: two-level segment/block memory mapper with wishbone setup
//
// Functional notes
// - segment table of 80H entries, indexed by segment
// - segment entry: segment protection, or block table
// - eight block tables of 20H entries each
// - block entry may redirect 2K to sram
// - block entry protection has four types
// - distinction setting splits normal/system, code/data/stack
// - split shrinks substituted segments: 8,4,4,2,2,1
// - mapping field: target, block table, nonexistent
// - user segments take one optional access restriction
// - block entry names sram block or target
// - block protection: data only, write protect, both
// - clear-all resets every entry to unprotected target
//
// Our own choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
module tlm_mapper #(
   parameter int SRAM_BW = tlm_pkg::SRAM_BW_DEF
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             nrst,
   // wishbone slave
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [11:0]      wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   // target bus access
   input  wire logic             acc_valid,
   input  wire tlm_pkg::tlm_acc_t acc,
   // mapping result
   output logic                  res_valid,
   output tlm_pkg::tlm_res_t     res,
   // interrupt
   output logic                  irq
);

   // ==========================================================
   // parameter check
   generate
      if (SRAM_BW < 1 || SRAM_BW > 8) begin : g_bad_bw
         $error("tlm_mapper: SRAM_BW must be 1 to 8");
      end
   endgenerate

   // ==========================================================
   // declarations
   logic                  ack_reg;
   logic                  bus_req;
   logic                  bus_wr;
   logic [1:0]            win;
   logic [31:0]           rd_next;
   logic [2:0]            dist_reg;
   logic [1:0]            irq_stat_reg;
   logic [1:0]            irq_mask_reg;
   logic [22:0]           last_vio_reg;
   logic                  clr_busy_reg;
   logic [7:0]            clr_cnt_reg;
   logic                  seg_we;
   logic [6:0]            seg_waddr;
   logic [tlm_pkg::SEG_WIDTH-1:0] seg_wdata;
   logic [tlm_pkg::SEG_WIDTH-1:0] seg_rdata;
   logic                  blk_we;
   logic [7:0]            blk_waddr;
   logic [tlm_pkg::BLK_WIDTH-1:0] blk_wdata;
   logic [tlm_pkg::BLK_WIDTH-1:0] blk_rdata;
   logic [7:0]            blk_raddr;
   logic                  s1_valid_reg;
   tlm_pkg::tlm_acc_t     s1_acc_reg;
   logic                  s2_valid_reg;
   tlm_pkg::tlm_acc_t     s2_acc_reg;
   tlm_pkg::tlm_seg_ent_t s2_seg_reg;
   tlm_pkg::tlm_seg_ent_t s1_seg;
   tlm_pkg::tlm_blk_ent_t s2_blk;
   logic [2:0]            tbl_sel;
   logic [1:0]            sp_bits;
   logic [2:0]            sub_sel;
   logic [2:0]            shift;
   tlm_pkg::tlm_res_t     dec;
   logic                  dec_nonex;
   logic                  is_code;
   logic                  wr_ctrl;
   logic                  wr_dist;
   logic                  wr_mask;
   logic                  wr_stat;
   logic [1:0]            stat_set;
   logic [1:0]            stat_clr;

   assign s1_seg  = tlm_pkg::tlm_seg_ent_t'(seg_rdata);
   assign s2_blk  = tlm_pkg::tlm_blk_ent_t'(blk_rdata);
   assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg && !clr_busy_reg;
   assign win     = wb_adr_i[11:10];

   // ==========================================================
   // register write strobes, at the edge that samples ack high
   assign bus_wr   = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && (wb_sel_i != 4'h0);
   assign wr_ctrl  = bus_wr && (wb_adr_i == tlm_pkg::OFS_CTRL);
   assign wr_dist  = bus_wr && (wb_adr_i == tlm_pkg::OFS_DIST);
   assign wr_mask  = bus_wr && (wb_adr_i == tlm_pkg::OFS_IRQ_MASK);
   assign wr_stat  = bus_wr && (wb_adr_i == tlm_pkg::OFS_IRQ_STAT);
   assign stat_clr = wr_stat ? wb_dat_i[1:0] : 2'h0;

   // ==========================================================
   // table memories
   tlm_ram #(.DATA_W(tlm_pkg::SEG_WIDTH), .AW(tlm_pkg::SEG_AW)) u_seg_tbl (
      .clk   (clk),
      .we    (seg_we),
      .waddr (seg_waddr),
      .wdata (seg_wdata),
      .raddr (acc.seg),
      .rdata (seg_rdata)
   );

   tlm_ram #(.DATA_W(tlm_pkg::BLK_WIDTH), .AW(tlm_pkg::BLK_AW)) u_blk_tbl (
      .clk   (clk),
      .we    (blk_we),
      .waddr (blk_waddr),
      .wdata (blk_wdata),
      .raddr (blk_raddr),
      .rdata (blk_rdata)
   );

   // ==========================================================
   // table write port: clear sequencer or bus
   always_comb begin
      if (clr_busy_reg) begin
         seg_we    = (clr_cnt_reg < 8'(tlm_pkg::SEG_ENTRIES));
         seg_waddr = clr_cnt_reg[6:0];
         seg_wdata = '0;
         blk_we    = 1'b1;
         blk_waddr = clr_cnt_reg;
         blk_wdata = '0;
      end else begin
         seg_we    = bus_wr && (win == tlm_pkg::WIN_SEG) && (wb_adr_i[9] == 1'b0);
         seg_waddr = wb_adr_i[8:2];
         seg_wdata = wb_dat_i[tlm_pkg::SEG_WIDTH-1:0];
         blk_we    = bus_wr && (win == tlm_pkg::WIN_BLK);
         blk_waddr = wb_adr_i[9:2];
         blk_wdata = wb_dat_i[tlm_pkg::BLK_WIDTH-1:0];
         blk_wdata[8:1] = wb_dat_i[8:1] & 8'((9'h100 >> (8 - SRAM_BW)) - 9'h1);
      end
   end

   // ==========================================================
   // clear-all sequencer
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         clr_busy_reg <= 1'b0;
         clr_cnt_reg  <= 8'h00;
      end else if (clr_busy_reg) begin
         clr_cnt_reg <= clr_cnt_reg + 8'h01;
         if (clr_cnt_reg == 8'(tlm_pkg::CLR_LAST)) begin
            clr_busy_reg <= 1'b0;
         end
      end else if (wr_ctrl && wb_dat_i[tlm_pkg::CTRL_CLEAR_BIT]) begin
         clr_busy_reg <= 1'b1;
         clr_cnt_reg  <= 8'h00;
      end
   end

   // ==========================================================
   // wishbone ack and read data
   always_comb begin
      rd_next = 32'h0000_0000;
      case (wb_adr_i)
         tlm_pkg::OFS_CTRL:     rd_next = {31'h0, clr_busy_reg};
         tlm_pkg::OFS_DIST:     rd_next = {29'h0, dist_reg};
         tlm_pkg::OFS_STATUS:   rd_next = {29'h0, s2_valid_reg, irq, clr_busy_reg};
         tlm_pkg::OFS_IRQ_STAT: rd_next = {30'h0, irq_stat_reg};
         tlm_pkg::OFS_IRQ_MASK: rd_next = {30'h0, irq_mask_reg};
         tlm_pkg::OFS_LAST_VIO: rd_next = {9'h0, last_vio_reg};
         default:               rd_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ack_reg  <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         ack_reg  <= bus_req;
         wb_dat_o <= bus_req ? rd_next : 32'h0000_0000;
      end
   end

   assign wb_ack_o = ack_reg;

   // ==========================================================
   // distinction and mask registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dist_reg     <= tlm_pkg::DIST_RST;
         irq_mask_reg <= tlm_pkg::IRQ_MASK_RST;
      end else begin
         if (wr_dist) begin
            dist_reg <= wb_dat_i[2:0];
         end
         if (wr_mask) begin
            irq_mask_reg <= wb_dat_i[1:0];
         end
      end
   end

   // ==========================================================
   // stage 1: segment entry read, block table select
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1_valid_reg <= 1'b0;
         s1_acc_reg   <= '0;
      end else begin
         s1_valid_reg <= acc_valid;
         s1_acc_reg   <= acc;
      end
   end

   // space bits and number of tables per substituted segment
   always_comb begin
      sp_bits = 2'h0;
      shift   = 3'h0;
      if (dist_reg[tlm_pkg::DIST_STACK_BIT]) begin
         sp_bits = s1_acc_reg.space;
         shift   = 3'h2;
      end else if (dist_reg[tlm_pkg::DIST_CD_BIT]) begin
         sp_bits = {1'b0, s1_acc_reg.space != tlm_pkg::SPACE_CODE};
         shift   = 3'h1;
      end
      sub_sel = {1'b0, sp_bits};
      if (dist_reg[tlm_pkg::DIST_SYS_BIT]) begin
         sub_sel = sub_sel | (3'(s1_acc_reg.sys) << shift[1:0]);
         shift   = shift + 3'h1;
      end
      tbl_sel = 3'(s1_seg.group << shift) | sub_sel;
      if (shift > 3'h2) begin
         tbl_sel = sub_sel;
      end
      blk_raddr = {tbl_sel, s1_acc_reg.off[15:tlm_pkg::OFF_BLK_LSB]};
   end

   // ==========================================================
   // stage 2: block entry read
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s2_valid_reg <= 1'b0;
         s2_acc_reg   <= '0;
         s2_seg_reg   <= '0;
      end else begin
         s2_valid_reg <= s1_valid_reg;
         s2_acc_reg   <= s1_acc_reg;
         s2_seg_reg   <= s1_seg;
      end
   end

   // ==========================================================
   // decision
   always_comb begin
      is_code   = (s2_acc_reg.space == tlm_pkg::SPACE_CODE);
      dec       = '0;
      dec_nonex = 1'b0;
      case (s2_seg_reg.map)
         tlm_pkg::TLM_MAP_USER: begin
            dec.route = tlm_pkg::TLM_ROUTE_TARGET;
            case (s2_seg_reg.prot)
               tlm_pkg::TLM_SP_SYS_ONLY:  dec.viol = !s2_acc_reg.sys;
               tlm_pkg::TLM_SP_NORM_ONLY: dec.viol = s2_acc_reg.sys;
               tlm_pkg::TLM_SP_CODE_ONLY: dec.viol = !is_code;
               tlm_pkg::TLM_SP_DATA_ONLY: dec.viol = is_code;
               tlm_pkg::TLM_SP_WP_ALL:    dec.viol = s2_acc_reg.wr;
               tlm_pkg::TLM_SP_WP_DATA:   dec.viol = s2_acc_reg.wr && !is_code;
               default:                   dec.viol = 1'b0;
            endcase
         end
         tlm_pkg::TLM_MAP_MAPPED: begin
            if (s2_blk.sub) begin
               dec.route = tlm_pkg::TLM_ROUTE_SRAM;
               dec.blk   = s2_blk.blk;
            end else begin
               dec.route = tlm_pkg::TLM_ROUTE_TARGET;
            end
            dec.viol = (s2_blk.data_only && is_code) || (s2_blk.write_protect && s2_acc_reg.wr);
         end
         default: begin
            dec.route = tlm_pkg::TLM_ROUTE_NONE;
            dec.viol  = 1'b1;
            dec_nonex = 1'b1;
         end
      endcase
      dec.wr_ok = s2_acc_reg.wr && !dec.viol;
   end

   // ==========================================================
   // result outputs
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         res_valid <= 1'b0;
         res       <= '0;
      end else begin
         res_valid <= s2_valid_reg;
         res       <= s2_valid_reg ? dec : '0;
      end
   end

   // ==========================================================
   // violation events, last violation capture
   always_comb begin
      stat_set = 2'h0;
      if (s2_valid_reg && dec.viol) begin
         stat_set[tlm_pkg::IRQ_PROT_BIT]  = !dec_nonex;
         stat_set[tlm_pkg::IRQ_NONEX_BIT] = dec_nonex;
      end
   end

   // sticky status: a set wins over a clearing write
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_stat_reg <= 2'h0;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~stat_clr) | stat_set;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         last_vio_reg <= 23'h000000;
      end else if (s2_valid_reg && dec.viol) begin
         last_vio_reg <= {s2_acc_reg.seg, s2_acc_reg.off};
      end
   end

   // interrupt level from unmasked status
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_reg & irq_mask_reg);
      end
   end

endmodule // tlm_mapper

// ---- bench/tlm_mapper_assertions.sv ----
// checker: port-level properties of the memory mapper
`timescale 1ns/1ps
module tlm_mapper_checker (
   // clock and reset
   input wire logic              clk,
   input wire logic              nrst,
   // wishbone
   input wire logic              wb_cyc_i,
   input wire logic              wb_stb_i,
   input wire logic              wb_we_i,
   input wire logic [31:0]       wb_dat_o,
   input wire logic              wb_ack_o,
   // access and result
   input wire logic              acc_valid,
   input wire tlm_pkg::tlm_acc_t acc,
   input wire logic              res_valid,
   input wire tlm_pkg::tlm_res_t res,
   // interrupt
   input wire logic              irq
);
   // ==========================================================
   // properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   chk_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   chk_res_latency: assert property (acc_valid |-> ##3 res_valid)
      else $error("result not three cycles after access");
   chk_res_cause: assert property (res_valid |-> $past(acc_valid, 3))
      else $error("result without access");
   chk_res_quiet: assert property (!res_valid |-> res == '0)
      else $error("result not zero when idle");
   chk_wr_gate: assert property (res_valid |-> res.wr_ok == ($past(acc.wr, 3) && !res.viol))
      else $error("write permission wrong");
   chk_nonex_flag: assert property (res_valid && res.route == tlm_pkg::TLM_ROUTE_NONE |-> res.viol)
      else $error("nonexistent route without violation");
   chk_irq_cause: assert property ($rose(irq) |-> $past(res_valid && res.viol) || $past(wb_ack_o && wb_we_i, 2))
      else $error("interrupt rose without cause");
endmodule // tlm_mapper_checker

bind tlm_mapper tlm_mapper_checker chk_i (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .acc_valid(acc_valid), .acc(acc),
   .res_valid(res_valid), .res(res), .irq(irq));

// ---- bench/tlm_cpu_model.sv ----
// partner: target processor issuing segmented bus accesses
`timescale 1ns/1ps
module tlm_cpu_model (
   // clock
   input wire logic              clk,
   // access out
   output logic                  acc_valid,
   output tlm_pkg::tlm_acc_t     acc,
   // result in
   input wire logic              res_valid,
   input wire tlm_pkg::tlm_res_t res
);
   initial begin
      acc_valid = 1'b0;
      acc = '0;
   end

   // ==========================================================
   // one access, then wait for its result
   task automatic issue(input tlm_pkg::tlm_acc_t a, output tlm_pkg::tlm_res_t r);
      int n;
      n = 0;
      @(posedge clk);
      acc_valid <= 1'b1;
      acc <= a;
      @(posedge clk);
      acc_valid <= 1'b0;
      acc <= ~a;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (res_valid !== 1'b1 && n < 8);
      r = res;
   endtask
endmodule // tlm_cpu_model

// ---- bench/tb_top.sv ----
// testbench: register and access sequences for the memory mapper
`timescale 1ns/1ps
module tb_top;
   logic              clk, nrst, wb_cyc, wb_stb, wb_we, wb_ack, acc_valid, res_valid, irq;
   logic [3:0]        wb_sel;
   logic [11:0]       wb_adr;
   logic [31:0]       wb_dat, wb_q, rd;
   tlm_pkg::tlm_acc_t acc;
   tlm_pkg::tlm_res_t res;
   int                fails = 0, comparisons = 0, cyc_n = 0;

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   tlm_mapper uut (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_q), .wb_ack_o(wb_ack),
      .acc_valid(acc_valid), .acc(acc), .res_valid(res_valid), .res(res), .irq(irq));
   tlm_cpu_model cpu (.clk(clk), .acc_valid(acc_valid), .acc(acc), .res_valid(res_valid), .res(res));

   // ==========================================================
   // tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic close_out();
      if (fails == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic bus(input logic we, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 400);
      if (n >= 400) fails++;
      rd = wb_q;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask

   task automatic go(input logic [6:0] s, input logic [15:0] o, input logic [3:0] k, input logic [11:0] e);
      tlm_pkg::tlm_res_t r;
      cpu.issue({s, o, k}, r);
      chk({20'h0, r}, {20'h0, e});
   endtask

   task automatic irq_is(input logic v);
      repeat (2) @(posedge clk);
      #1;
      chk({31'h0, irq}, {31'h0, v});
   endtask

   always @(posedge clk) begin
      cyc_n++;
      if (cyc_n > 20000) begin
         fails++;
         close_out();
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      logic [11:0] zero_regs [4];
      zero_regs = '{tlm_pkg::OFS_DIST, tlm_pkg::OFS_IRQ_STAT, tlm_pkg::OFS_IRQ_MASK, 12'h020};
      {nrst, wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = '0;
      wb_sel = 4'hf;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      bus(1'b1, 12'h020, 32'hffff_ffff);
      bus(1'b1, tlm_pkg::OFS_CTRL, 32'h1);
      bus(1'b0, tlm_pkg::OFS_CTRL, 32'h0);
      chk(rd, 32'h0);
      foreach (zero_regs[i]) begin
         bus(1'b0, zero_regs[i], 32'h0);
         chk(rd, 32'h0);
      end
      go(7'h05, 16'h1234, 4'h9, 12'h002);
      for (int p = 1; p <= 6; p++) begin
         bus(1'b1, tlm_pkg::OFS_SEG_BASE + 12'h01c, {27'h0, p[2:0], 2'h0});
         go(7'h07, 16'h0100, 4'h9, (p == 1 || p == 3 || p >= 5) ? 12'h001 : 12'h002);
         go(7'h07, 16'h0100, 4'h8, (p == 1 || p == 4 || p == 5) ? 12'h001 : 12'h002);
      end
      bus(1'b1, tlm_pkg::OFS_SEG_BASE + 12'h02c, 32'h2);
      go(7'h0b, 16'h0000, 4'h1, 12'h801);
      go(7'h0b, 16'h4000, 4'h9, 12'h801);
      bus(1'b1, tlm_pkg::OFS_SEG_BASE + 12'h024, 32'h1);
      bus(1'b1, tlm_pkg::OFS_BLK_BASE + 12'h00c, 32'h55);
      bus(1'b1, tlm_pkg::OFS_BLK_BASE + 12'h010, 32'h400);
      bus(1'b1, tlm_pkg::OFS_BLK_BASE + 12'h014, 32'h200);
      bus(1'b1, tlm_pkg::OFS_BLK_BASE + 12'h018, 32'h600);
      go(7'h09, 16'h1800, 4'h1, 12'h4a8);
      go(7'h09, 16'h1fff, 4'h9, 12'h4aa);
      go(7'h09, 16'h0000, 4'h1, 12'h000);
      go(7'h09, 16'h2000, 4'h9, 12'h001);
      go(7'h09, 16'h2000, 4'h1, 12'h000);
      go(7'h09, 16'h2800, 4'h0, 12'h001);
      go(7'h09, 16'h2800, 4'h2, 12'h000);
      go(7'h09, 16'h3000, 4'h9, 12'h001);
      go(7'h09, 16'h3000, 4'h1, 12'h000);
      bus(1'b1, tlm_pkg::OFS_DIST, 32'h1);
      bus(1'b1, tlm_pkg::OFS_SEG_BASE + 12'h034, 32'h21);
      bus(1'b1, tlm_pkg::OFS_BLK_BASE + 12'h180, 32'h0f);
      go(7'h0d, 16'h0000, 4'h4, 12'h41c);
      go(7'h0d, 16'h0000, 4'h0, 12'h000);
      bus(1'b1, tlm_pkg::OFS_DIST, 32'h4);
      bus(1'b1, tlm_pkg::OFS_BLK_BASE + 12'h300, 32'h13);
      go(7'h0d, 16'h0000, 4'h2, 12'h424);
      go(7'h0d, 16'h0000, 4'h1, 12'h000);
      bus(1'b0, tlm_pkg::OFS_IRQ_STAT, 32'h0);
      chk(rd, 32'h3);
      bus(1'b0, tlm_pkg::OFS_LAST_VIO, 32'h0);
      chk(rd, 32'h0009_3000);
      irq_is(1'b0);
      bus(1'b1, tlm_pkg::OFS_IRQ_MASK, 32'h1);
      irq_is(1'b1);
      bus(1'b1, tlm_pkg::OFS_IRQ_STAT, 32'h1);
      irq_is(1'b0);
      bus(1'b0, tlm_pkg::OFS_IRQ_STAT, 32'h0);
      chk(rd, 32'h2);
      bus(1'b1, tlm_pkg::OFS_IRQ_MASK, 32'h3);
      irq_is(1'b1);
      bus(1'b1, tlm_pkg::OFS_IRQ_STAT, 32'h2);
      irq_is(1'b0);
      bus(1'b1, tlm_pkg::OFS_CTRL, 32'h1);
      bus(1'b0, tlm_pkg::OFS_DIST, 32'h0);
      chk(rd, 32'h4);
      go(7'h09, 16'h2000, 4'h9, 12'h002);
      go(7'h0b, 16'h0000, 4'h1, 12'h000);
      close_out();
   end
endmodule // tb_top
